// ===== hw/agcl_pkg.sv
// Shared constants for the AGC loop control block
package agcl_pkg;

  // Avalon-MM slave geometry
  localparam int AVS_ADDR_W = 5;
  localparam int AVS_DATA_W = 32;

  // Register byte offsets
  localparam logic [AVS_ADDR_W-1:0] OFS_CFG_ONE = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] OFS_LIMITS = 5'h04;
  localparam logic [AVS_ADDR_W-1:0] OFS_SAMPLE_STROBE = 5'h08;
  localparam logic [AVS_ADDR_W-1:0] OFS_GAIN_READBACK = 5'h0C;
  localparam logic [AVS_ADDR_W-1:0] OFS_GAIN_PRESET = 5'h10;
  localparam logic [AVS_ADDR_W-1:0] OFS_STATUS = 5'h14;

  // Field positions of gain_loop_config_one
  localparam int CFG_SYNC_BIT = 29;
  localparam int THR_MSB = 28;
  localparam int THR_LSB = 16;
  localparam int G1_MANT_MSB = 15;
  localparam int G1_MANT_LSB = 12;
  localparam int G1_EXP_MSB = 11;
  localparam int G1_EXP_LSB = 8;
  localparam int G0_MANT_MSB = 7;
  localparam int G0_MANT_LSB = 4;
  localparam int G0_EXP_MSB = 3;
  localparam int G0_EXP_LSB = 0;

  // Field positions of gain_loop_limits
  localparam int LIM_UP_MSB = 27;
  localparam int LIM_UP_LSB = 16;
  localparam int LIM_LO_MSB = 11;
  localparam int LIM_LO_LSB = 0;

  // Status bit positions
  localparam int STAT_AT_UPPER = 0;
  localparam int STAT_AT_LOWER = 1;
  localparam int STAT_GAIN_SEL = 2;

  // Writable bit masks; reserved bits stay zero
  localparam logic [AVS_DATA_W-1:0] CFG_ONE_MASK = 32'h3FFF_FFFF;
  localparam logic [AVS_DATA_W-1:0] LIMITS_MASK = 32'h0FFF_0FFF;
  localparam logic [AVS_DATA_W-1:0] PRESET_MASK = 32'h0000_0FFF;

  // Reset values: loop gains zero, limits wide open, preset at minimum
  localparam logic [AVS_DATA_W-1:0] CFG_ONE_RST = 32'h0000_0000;
  localparam logic [AVS_DATA_W-1:0] LIMITS_RST = 32'h0FFF_0000;
  localparam logic [AVS_DATA_W-1:0] PRESET_RST = 32'h0000_0000;

  // Datapath widths
  localparam int THR_W = 13;
  localparam int MAG_W = 12;
  localparam int ERR_W = 15;
  localparam int NIB_W = 4;
  localparam int LIM_W = 12;
  localparam int FRAC_W = 23;
  localparam int ACC_W = LIM_W + FRAC_W;
  localparam int STEP_W = 35;

endpackage

// ===== hw/agcl_error_step.sv
// Gain error and per-sample loop gain step
`timescale 1ns/1ps
`default_nettype none
module agcl_error_step (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [agcl_pkg::THR_W-1:0] threshold,
  input wire logic [agcl_pkg::MAG_W-1:0] magnitude,
  input wire logic [agcl_pkg::NIB_W-1:0] mantissa,
  input wire logic [agcl_pkg::NIB_W-1:0] exponent,
  output logic step_valid,
  output logic signed [agcl_pkg::STEP_W-1:0] step
);
  import agcl_pkg::*;

  logic [MAG_W+1:0] mag_scaled;
  logic signed [ERR_W-1:0] err;
  logic signed [ERR_W+NIB_W:0] prod;
  logic signed [STEP_W-1:0] next_step;
  logic next_step_valid;

  always_comb begin
    // 1 + 1/2 + 1/16 + 1/32 stands in for the 1.6 magnitude weight
    mag_scaled = (MAG_W+2)'(magnitude) + (MAG_W+2)'(magnitude >> 1)
               + (MAG_W+2)'(magnitude >> 4) + (MAG_W+2)'(magnitude >> 5);
    // Threshold is signed, LSB 2^-10, same scale as magnitude
    err = ERR_W'(signed'(threshold)) - signed'(ERR_W'(mag_scaled));
    // Mantissa taken as value/16; the /16 sits in the accumulator fraction
    prod = err * signed'({1'b0, mantissa});
    // Accumulator fraction is 2^-23 of a limit LSB, so the step is a left shift by the exponent
    next_step = STEP_W'(prod) <<< exponent;
    next_step_valid = in_valid;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      step <= '0;
      step_valid <= 1'b0;
    end else begin
      step <= next_step;
      step_valid <= next_step_valid;
    end
  end

endmodule // agcl_error_step
`default_nettype wire

// ===== hw/agcl_sat.sv
// Saturating gain accumulator adder
`timescale 1ns/1ps
`default_nettype none
module agcl_sat (
  input wire logic [agcl_pkg::ACC_W-1:0] acc,
  input wire logic signed [agcl_pkg::STEP_W-1:0] step,
  input wire logic [agcl_pkg::LIM_W-1:0] upper,
  input wire logic [agcl_pkg::LIM_W-1:0] lower,
  output logic [agcl_pkg::ACC_W-1:0] result
);
  import agcl_pkg::*;

  logic signed [ACC_W+1:0] sum;
  logic signed [ACC_W+1:0] up_full;
  logic signed [ACC_W+1:0] lo_full;

  always_comb begin
    sum = signed'((ACC_W+2)'(acc)) + (ACC_W+2)'(step);
    up_full = signed'((ACC_W+2)'({upper, {FRAC_W{1'b0}}}));
    lo_full = signed'((ACC_W+2)'({lower, {FRAC_W{1'b0}}}));
    // Upper checked first so a sum meeting both crossed limits settles on the upper one
    if (sum >= up_full) begin
      result = {upper, {FRAC_W{1'b0}}};
    end else if (sum <= lo_full) begin
      result = {lower, {FRAC_W{1'b0}}};
    end else begin
      result = ACC_W'(sum);
    end
  end

endmodule // agcl_sat
`default_nettype wire

// ===== hw/agcl_top.sv
// AGC loop control: register slave, gain accumulator, sync load and gain snapshot
`timescale 1ns/1ps
`default_nettype none
module agcl_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [agcl_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [agcl_pkg::AVS_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [agcl_pkg::AVS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mag_valid,
  input wire logic [agcl_pkg::MAG_W-1:0] mag_in,
  input wire logic filter_sync_input,
  input wire logic loop_gain_select,
  output logic [agcl_pkg::LIM_W-1:0] gain_level,
  output logic gain_at_upper,
  output logic gain_at_lower
);
  import agcl_pkg::*;

  // Merge a write into a register, honouring byte lanes and writable bits
  function automatic logic [AVS_DATA_W-1:0] be_merge(
    input logic [AVS_DATA_W-1:0] old_val,
    input logic [AVS_DATA_W-1:0] wdata,
    input logic [3:0] be,
    input logic [AVS_DATA_W-1:0] mask
  );
    logic [AVS_DATA_W-1:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old_val & ~lane) | (wdata & lane);
  endfunction

  // Register file state
  logic [AVS_DATA_W-1:0] gain_loop_config_one;
  logic [AVS_DATA_W-1:0] gain_loop_limits;
  logic [AVS_DATA_W-1:0] gain_preset;
  logic [LIM_W-1:0] gain_snapshot;
  logic [AVS_DATA_W-1:0] next_config_one;
  logic [AVS_DATA_W-1:0] next_limits;
  logic [AVS_DATA_W-1:0] next_preset;
  logic [LIM_W-1:0] next_snapshot;
  logic [AVS_DATA_W-1:0] next_readdata;
  logic next_waitrequest;
  logic bus_req;
  logic bus_commit;

  // Loop state
  logic [ACC_W-1:0] gain_acc;
  logic sync_prev;
  logic [ACC_W-1:0] next_acc;
  logic next_sync_prev;
  logic [LIM_W-1:0] next_gain_level;
  logic next_at_upper;
  logic next_at_lower;

  // Loop datapath wiring
  logic [NIB_W-1:0] sel_mantissa;
  logic [NIB_W-1:0] sel_exponent;
  logic [LIM_W-1:0] upper_limit;
  logic [LIM_W-1:0] lower_limit;
  logic step_valid;
  logic signed [STEP_W-1:0] step;
  logic [ACC_W-1:0] acc_sat;
  logic sync_load;

  // Read multiplexer for the mapped offsets; unmapped reads answer zero
  function automatic logic [AVS_DATA_W-1:0] read_mux(input logic [AVS_ADDR_W-1:0] addr);
    logic [AVS_DATA_W-1:0] val;
    val = '0;
    case (addr)
      OFS_CFG_ONE: begin
        val = gain_loop_config_one;
      end
      OFS_LIMITS: begin
        val = gain_loop_limits;
      end
      OFS_GAIN_READBACK: begin
        val = AVS_DATA_W'(gain_snapshot);
      end
      OFS_GAIN_PRESET: begin
        val = gain_preset;
      end
      OFS_STATUS: begin
        val[STAT_AT_UPPER] = gain_at_upper;
        val[STAT_AT_LOWER] = gain_at_lower;
        val[STAT_GAIN_SEL] = loop_gain_select;
      end
      default: begin
        val = '0;
      end
    endcase
    return val;
  endfunction

  // Bus slave: one wait cycle on every access, so read data is always registered
  always_comb begin
    bus_req = avs_read | avs_write;
    bus_commit = bus_req & ~avs_waitrequest;
    next_waitrequest = 1'b1;
    if (bus_req && avs_waitrequest) begin
      next_waitrequest = 1'b0;
    end
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      next_readdata = read_mux(avs_address);
    end
    next_config_one = gain_loop_config_one;
    next_limits = gain_loop_limits;
    next_preset = gain_preset;
    next_snapshot = gain_snapshot;
    if (bus_commit && avs_write) begin
      case (avs_address)
        OFS_CFG_ONE: begin
          next_config_one = be_merge(gain_loop_config_one, avs_writedata, avs_byteenable,
                                     CFG_ONE_MASK);
        end
        OFS_LIMITS: begin
          next_limits = be_merge(gain_loop_limits, avs_writedata, avs_byteenable,
                                 LIMITS_MASK);
        end
        OFS_SAMPLE_STROBE: begin
          // Data and byte lanes are ignored; the write itself is the strobe
          next_snapshot = gain_acc[ACC_W-1 -: LIM_W];
        end
        OFS_GAIN_PRESET: begin
          next_preset = be_merge(gain_preset, avs_writedata, avs_byteenable, PRESET_MASK);
        end
        default: begin
          next_snapshot = gain_snapshot;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      gain_loop_config_one <= CFG_ONE_RST;
      gain_loop_limits <= LIMITS_RST;
      gain_preset <= PRESET_RST;
      gain_snapshot <= '0;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      gain_loop_config_one <= next_config_one;
      gain_loop_limits <= next_limits;
      gain_preset <= next_preset;
      gain_snapshot <= next_snapshot;
    end
  end

  // Loop gain set selection and limit fields
  always_comb begin
    if (loop_gain_select) begin
      sel_mantissa = gain_loop_config_one[G1_MANT_MSB:G1_MANT_LSB];
      sel_exponent = gain_loop_config_one[G1_EXP_MSB:G1_EXP_LSB];
    end else begin
      sel_mantissa = gain_loop_config_one[G0_MANT_MSB:G0_MANT_LSB];
      sel_exponent = gain_loop_config_one[G0_EXP_MSB:G0_EXP_LSB];
    end
    // Mantissa sits over exponent in each gain byte, so the raw word is not a piecewise-linear log2 of gain
    upper_limit = gain_loop_limits[LIM_UP_MSB:LIM_UP_LSB];
    lower_limit = gain_loop_limits[LIM_LO_MSB:LIM_LO_LSB];
  end

  agcl_error_step u_error_step (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(mag_valid),
    .threshold(gain_loop_config_one[THR_MSB:THR_LSB]),
    .magnitude(mag_in),
    .mantissa(sel_mantissa),
    .exponent(sel_exponent),
    .step_valid(step_valid),
    .step(step)
  );

  agcl_sat u_sat (
    .acc(gain_acc),
    .step(step),
    .upper(upper_limit),
    .lower(lower_limit),
    .result(acc_sat)
  );

  // Accumulator: a sync load wins over a step landing in the same cycle
  always_comb begin
    next_sync_prev = filter_sync_input;
    sync_load = gain_loop_config_one[CFG_SYNC_BIT] & filter_sync_input & ~sync_prev;
    next_acc = gain_acc;
    if (sync_load) begin
      next_acc = {gain_preset[LIM_W-1:0], {FRAC_W{1'b0}}};
    end else if (step_valid) begin
      next_acc = acc_sat;
    end
    next_gain_level = next_acc[ACC_W-1 -: LIM_W];
    next_at_upper = next_gain_level >= upper_limit;
    next_at_lower = next_gain_level <= lower_limit;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gain_acc <= '0;
      sync_prev <= 1'b0;
      gain_level <= '0;
      gain_at_upper <= 1'b0;
      gain_at_lower <= 1'b0;
    end else begin
      gain_acc <= next_acc;
      sync_prev <= next_sync_prev;
      gain_level <= next_gain_level;
      gain_at_upper <= next_at_upper;
      gain_at_lower <= next_at_lower;
    end
  end

endmodule // agcl_top
`default_nettype wire

// ===== tb/agcl_properties.sv
// Port-level checks of the AGC loop control block
`timescale 1ns/1ps
`default_nettype none
module agcl_properties
  import agcl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [agcl_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [agcl_pkg::AVS_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [agcl_pkg::AVS_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic mag_valid,
  input wire logic [agcl_pkg::MAG_W-1:0] mag_in,
  input wire logic filter_sync_input,
  input wire logic loop_gain_select,
  input wire logic [agcl_pkg::LIM_W-1:0] gain_level,
  input wire logic gain_at_upper,
  input wire logic gain_at_lower
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic rd_done;
  assign rd_done = avs_read && !avs_waitrequest;
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  a_idle_wait_high: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest fell with no request");
  // Gain moves only one edge after a sample or on a sync rise
  // A sample moves gain_level one edge later and a sync rise on the edge that samples it
  a_gain_hold_idle: assert property (!mag_valid ##1 !$rose(filter_sync_input) ##1 1'b1 |-> $stable(gain_level))
    else $error("gain level moved without cause");
  a_strobe_reads_zero: assert property (rd_done && avs_address == OFS_SAMPLE_STROBE |-> avs_readdata == 32'h0)
    else $error("strobe location read nonzero");
  a_cfg_resv_zero: assert property (rd_done && avs_address == OFS_CFG_ONE |-> avs_readdata[31:30] == 2'h0)
    else $error("config reserved bits nonzero");
  a_lim_resv_zero: assert property (rd_done && avs_address == OFS_LIMITS |-> (avs_readdata & ~LIMITS_MASK) == 32'h0)
    else $error("limits reserved bits nonzero");
  a_unmapped_zero: assert property (rd_done && avs_address > OFS_STATUS |-> avs_readdata == 32'h0)
    else $error("unmapped read nonzero");
  a_status_flags: assert property (rd_done && avs_address == OFS_STATUS |->
    avs_readdata[1:0] == $past({gain_at_lower, gain_at_upper})) else $error("status flags wrong");
  c_sync_rise: cover property ($rose(filter_sync_input));
  c_at_upper: cover property ($rose(gain_at_upper));
  c_at_lower: cover property ($rose(gain_at_lower));
endmodule // agcl_properties
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench of the AGC loop control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import agcl_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AVS_ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic mag_valid = 1'b0;
  logic [11:0] mag_in = 12'h000;
  logic filter_sync_input = 1'b0;
  logic loop_gain_select = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] gain_level;
  logic gain_at_upper;
  logic gain_at_lower;
  int failures = 0;
  int check_count = 0;
  agcl_top i_agcl_top (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mag_valid(mag_valid), .mag_in(mag_in),
    .filter_sync_input(filter_sync_input), .loop_gain_select(loop_gain_select), .gain_level(gain_level),
    .gain_at_upper(gain_at_upper), .gain_at_lower(gain_at_lower));
  always #10 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Holds the request until waitrequest is sampled low, never assuming latency
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      failures++;
      end_of_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask
  task automatic samp(input int n, input logic [11:0] m);
    @(posedge core_clk);
    mag_valid <= 1'b1;
    mag_in <= m;
    repeat (n) @(posedge core_clk);
    mag_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic sync_pulse();
    @(posedge core_clk);
    filter_sync_input <= 1'b1;
    repeat (2) @(posedge core_clk);
    filter_sync_input <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic t_regs();
    rdchk("cfg rst", OFS_CFG_ONE, 32'h0000_0000);
    rdchk("lim rst", OFS_LIMITS, 32'h0FFF_0000);
    rdchk("preset rst", OFS_GAIN_PRESET, 32'h0000_0000);
    rdchk("unmapped", 5'h18, 32'h0000_0000);
    chk("at lower", {31'h0, gain_at_lower}, 32'h1);
    wr(OFS_CFG_ONE, 32'hFFFF_FFFF);
    rdchk("cfg mask", OFS_CFG_ONE, 32'h3FFF_FFFF);
    wr(OFS_LIMITS, 32'hFFFF_FFFF);
    rdchk("lim mask", OFS_LIMITS, 32'h0FFF_0FFF);
    rdchk("strobe rd", OFS_SAMPLE_STROBE, 32'h0);
    wr(OFS_LIMITS, 32'h0FFF_0000);
    $display("test regs done");
  endtask
  // Threshold 1.0, set0 0.5 x 2^15 gives 32 LSB per sample at zero magnitude
  task automatic t_loop();
    wr(OFS_CFG_ONE, 32'h2400_008F);
    wr(OFS_GAIN_PRESET, 32'h0000_0345);
    sync_pulse();
    chk("sync load", {20'h0, gain_level}, 32'h345);
    samp(1, 12'h000);
    chk("step set0", {20'h0, gain_level}, 32'h365);
    samp(1, 12'h200);
    chk("step mag", {20'h0, gain_level}, 32'h36B);
    loop_gain_select <= 1'b1;
    samp(1, 12'h000);
    chk("set1 zero", {20'h0, gain_level}, 32'h36B);
    wr(OFS_CFG_ONE, 32'h2400_4F8F);
    samp(1, 12'h000);
    chk("set1 step", {20'h0, gain_level}, 32'h37B);
    $display("test loop done");
  endtask
  task automatic t_limits();
    wr(OFS_LIMITS, 32'h03A0_0300);
    loop_gain_select <= 1'b0;
    samp(10, 12'h000);
    chk("sat upper", {19'h0, gain_at_upper, gain_level}, 32'h13A0);
    wr(OFS_CFG_ONE, 32'h2000_008F);
    samp(10, 12'h400);
    chk("sat lower", {19'h0, gain_at_lower, gain_level}, 32'h1300);
    $display("test limits done");
  endtask
  task automatic t_strobe();
    wr(OFS_SAMPLE_STROBE, 32'h0);
    sync_pulse();
    rdchk("snapshot", OFS_GAIN_READBACK, 32'h0000_0300);
    wr(OFS_CFG_ONE, 32'h0000_008F);
    wr(OFS_GAIN_PRESET, 32'h0000_0399);
    sync_pulse();
    chk("no sync", {20'h0, gain_level}, 32'h345);
    @(posedge core_clk);
    loop_gain_select <= 1'b1;
    rdchk("status", OFS_STATUS, 32'h0000_0004);
    $display("test strobe done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_loop();
    t_limits();
    t_strobe();
    end_of_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule // tb_top
bind agcl_top agcl_properties i_agcl_properties (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mag_valid(mag_valid), .mag_in(mag_in),
  .filter_sync_input(filter_sync_input), .loop_gain_select(loop_gain_select), .gain_level(gain_level),
  .gain_at_upper(gain_at_upper), .gain_at_lower(gain_at_lower));
`default_nettype wire
